// >>> dspcp_device.sv
// Device end of the control processor host port.
//
// How it works
// - Eight address lines select interface register.
// - Data bus driven by device only on reads.
// - Select high makes strobes ignored.
// - Select and read low drive register.
// - Select and write low capture data.
// - Wait low until access completes; host holds.
// - Internal write to irq register raises irq.
// - Host servicing action drops irq.
// - Reset is low-high-low, high 10 us.
// - 200 ms initialisation after reset falls.
// - Stop high refuses new host accesses.
`timescale 1ns/1ps
`default_nettype none
module dspcp_device
  import dspcp_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = INIT_CYC,
  parameter int unsigned WAIT_CYCLES = ACCESS_CYC
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst,
  dspcp_if.device                bus,
  input  wire logic              i_core_we,
  input  wire logic [ADDR_W-1:0] i_core_addr,
  input  wire logic [DATA_W-1:0] i_core_wdata,
  input  wire logic              i_irq_enable,
  output logic                   o_host_wr,
  output logic      [ADDR_W-1:0] o_host_wr_addr,
  output logic      [DATA_W-1:0] o_host_wr_data,
  output logic                   o_ready,
  output logic                   o_stopped
);
  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W    = 32;
  localparam int unsigned WCNT_W   = 8;
  localparam int unsigned WCNT_MAX = (1 << WCNT_W) - 1;

  // The wait counter is kept narrow, so a wait setting that it cannot hold is refused here.
  if (WAIT_CYCLES < 1 || WAIT_CYCLES - 1 > WCNT_MAX || INIT_CYCLES < 1) begin : bad_counts
    $error("Wait or initialisation count out of range.");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_INIT = 4'h1,
    ST_IDLE = 4'h2,
    ST_WAIT = 4'h4,
    ST_DONE = 4'h8
  } dspcp_dst_t;

  typedef struct packed {
    dspcp_dst_t        st;
    logic [WCNT_W-1:0] wcnt;
    logic              rst_d;
    logic              irq;
    logic              is_read;
    logic [DATA_W-1:0] rdata;
    logic              rd_oe;
    logic              wr_pulse;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
  } dspcp_dev_t;

  // Reset value of the whole state word; the interface registers are left out on purpose.
  localparam dspcp_dev_t DEV_RESET = '{
    st:       ST_INIT,
    wcnt:     '0,
    rst_d:    1'b0,
    irq:      1'b0,
    is_read:  1'b0,
    rdata:    ZERO_BYTE,
    rd_oe:    1'b0,
    wr_pulse: 1'b0,
    wr_addr:  ZERO_BYTE,
    wr_data:  ZERO_BYTE
  };

  dspcp_dev_t        s_ff;
  dspcp_dev_t        nxt_s;
  logic [DATA_W-1:0] regs [0:(1<<ADDR_W)-1];
  logic              init_done;
  logic              init_clear;

  // ----------------------------------------------------------------
  // Initialisation counter
  // ----------------------------------------------------------------
  // The long initialisation count lives outside the struct so a short count can be set for test.
  dspcp_cnt #(.WIDTH(CNT_W)) u_init (
    .i_sys_clk (i_sys_clk),
    .i_clear   (init_clear),
    .i_limit   (CNT_W'(INIT_CYCLES - 1)),
    .o_done    (init_done)
  );
  // Reset pulse falling edge restarts initialisation.
  assign init_clear = i_rst || (s_ff.rst_d && !bus.dev_reset);

  function automatic logic sel_rd(input logic cs_n, input logic rd_n);
    return !cs_n && !rd_n;
  endfunction

  function automatic logic sel_any(input logic cs_n, input logic rd_n, input logic wr_n);
    return !cs_n && (!rd_n || !wr_n);
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_s          = s_ff;
    nxt_s.rst_d    = bus.dev_reset;
    nxt_s.wr_pulse = 1'b0;
    unique case (s_ff.st)
      ST_INIT: begin
        nxt_s.rd_oe = 1'b0;
        if (init_done && !bus.dev_reset) begin
          nxt_s.st = ST_IDLE;
        end
      end
      ST_IDLE: begin
        // A refused access leaves the wait output high, so the host finishes without an answer.
        if (sel_any(bus.host_select_n, bus.host_read_n, bus.host_write_n) && !bus.dev_stop) begin
          nxt_s.st      = ST_WAIT;
          nxt_s.wcnt    = WCNT_W'(WAIT_CYCLES - 1);
          nxt_s.is_read = !bus.host_read_n;
        end
      end
      ST_WAIT: begin
        if (s_ff.wcnt != '0) begin
          nxt_s.wcnt = s_ff.wcnt - WCNT_W'(1);
        end else begin
          nxt_s.st = ST_DONE;
          if (s_ff.is_read) begin
            nxt_s.rdata = regs[bus.host_reg_addr];
            nxt_s.rd_oe = 1'b1;
            if (bus.host_reg_addr == IRQ_REG_ADDR) begin
              nxt_s.irq = 1'b0;
            end
          end else begin
            nxt_s.wr_pulse = 1'b1;
            nxt_s.wr_addr  = bus.host_reg_addr;
            nxt_s.wr_data  = bus.host_reg_data;
          end
        end
      end
      ST_DONE: begin
        // Waiting for the strobes to drop keeps one long strobe from being taken twice.
        if (!sel_any(bus.host_select_n, bus.host_read_n, bus.host_write_n)) begin
          nxt_s.st    = ST_IDLE;
          nxt_s.rd_oe = 1'b0;
        end
      end
    endcase
    // The set comes after the clear, so a request raised while the host reads is kept.
    if (i_core_we && i_core_addr == IRQ_REG_ADDR && i_irq_enable) begin
      nxt_s.irq = 1'b1;
    end
    if (bus.dev_reset) begin
      nxt_s.st    = ST_INIT;
      nxt_s.irq   = 1'b0;
      nxt_s.rd_oe = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s_ff <= DEV_RESET;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------------------------------
  // Interface registers
  // ----------------------------------------------------------------
  // A plain array keeps the 256 bytes out of reset, trading a defined start value for area.
  always_ff @(posedge i_sys_clk) begin
    if (i_core_we) begin
      regs[i_core_addr] <= i_core_wdata;
    end else if (s_ff.wr_pulse) begin
      regs[s_ff.wr_addr] <= s_ff.wr_data;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Read data is driven only while the read strobe stands, so the bus is free once the host lets go.
  assign bus.host_data_d    = s_ff.rdata;
  assign bus.host_data_d_oe = s_ff.rd_oe && sel_rd(bus.host_select_n, bus.host_read_n);
  assign bus.host_wait_n    = !(s_ff.st == ST_WAIT);
  assign bus.host_irq       = s_ff.irq;
  assign o_host_wr          = s_ff.wr_pulse;
  assign o_host_wr_addr     = s_ff.wr_addr;
  assign o_host_wr_data     = s_ff.wr_data;
  assign o_ready            = s_ff.st != ST_INIT;
  assign o_stopped          = bus.dev_stop;
endmodule
`default_nettype wire

// >>> dspcp_pkg.sv
// Shared constants for the control processor host port.
package dspcp_pkg;
  localparam int unsigned ADDR_W          = 8;
  localparam int unsigned DATA_W          = 8;
  localparam int unsigned CLK_MHZ         = 40;
  localparam int unsigned RST_HIGH_US     = 10;
  localparam int unsigned INIT_MS         = 200;
  localparam int unsigned RST_HIGH_CYC    = RST_HIGH_US * CLK_MHZ;
  localparam int unsigned INIT_CYC        = INIT_MS * 1000 * CLK_MHZ;
  localparam int unsigned ACCESS_CYC      = 2;
  localparam logic [7:0]  IRQ_REG_ADDR    = 8'hFF;
  localparam logic [7:0]  ZERO_BYTE       = 8'h00;
endpackage

// >>> dspcp_if.sv
// Parallel register bus joining the host end and the device end.
`timescale 1ns/1ps
`default_nettype none
interface dspcp_if;
  import dspcp_pkg::*;
  logic [ADDR_W-1:0] host_reg_addr;
  logic [DATA_W-1:0] host_data_h;
  logic              host_data_h_oe;
  logic [DATA_W-1:0] host_data_d;
  logic              host_data_d_oe;
  logic              host_select_n;
  logic              host_read_n;
  logic              host_write_n;
  logic              host_wait_n;
  logic              host_irq;
  logic              dev_reset;
  logic              dev_stop;
  wire  [DATA_W-1:0] host_reg_data = host_data_d_oe ? host_data_d :
                                     host_data_h_oe ? host_data_h : ZERO_BYTE;
  modport device (
    input  host_reg_addr, host_reg_data, host_select_n, host_read_n, host_write_n, dev_reset, dev_stop,
    output host_data_d, host_data_d_oe, host_wait_n, host_irq
  );
  modport host (
    input  host_reg_data, host_wait_n, host_irq,
    output host_reg_addr, host_data_h, host_data_h_oe, host_select_n, host_read_n, host_write_n,
           dev_reset, dev_stop
  );
endinterface
`default_nettype wire

// >>> dspcp_cnt.sv
// Saturating cycle counter shared by both ends.
`timescale 1ns/1ps
`default_nettype none
module dspcp_cnt #(
  parameter int unsigned WIDTH = 24
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_clear,
  input  wire logic [WIDTH-1:0] i_limit,
  output logic                  o_done
);
  logic [WIDTH-1:0] cnt_ff;
  always_ff @(posedge i_sys_clk) begin
    if (i_clear) begin
      cnt_ff <= '0;
    end else if (cnt_ff != i_limit) begin
      cnt_ff <= cnt_ff + WIDTH'(1);
    end
  end
  assign o_done = (cnt_ff == i_limit) && !i_clear;
endmodule
`default_nettype wire

// >>> dspcp_host.sv
// Host end of the control processor host port.
`timescale 1ns/1ps
`default_nettype none
module dspcp_host
  import dspcp_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = INIT_CYC
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst,
  dspcp_if.host                  bus,
  input  wire logic              i_req,
  input  wire logic              i_req_write,
  input  wire logic [ADDR_W-1:0] i_req_addr,
  input  wire logic [DATA_W-1:0] i_req_wdata,
  input  wire logic              i_dev_reset_req,
  input  wire logic              i_stop,
  output logic                   o_busy,
  output logic                   o_done,
  output logic      [DATA_W-1:0] o_rdata,
  output logic                   o_irq
);
  if (INIT_CYCLES < 1) begin : bad_init
    $error("Initialisation count must be at least one.");
  end

  typedef enum logic [4:0] {
    HS_IDLE = 5'h01, HS_STROBE = 5'h02, HS_END = 5'h04, HS_RSTHI = 5'h08, HS_INIT = 5'h10
  } dspcp_hst_t;

  typedef struct packed {
    dspcp_hst_t        st;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic              done;
    logic              rst_o;
    logic              restart;
  } dspcp_host_t;

  dspcp_host_t s_ff;
  dspcp_host_t nxt_s;
  logic        cnt_done;
  logic        cnt_clear;

  dspcp_cnt #(.WIDTH(32)) u_cnt (
    .i_sys_clk (i_sys_clk),
    .i_clear   (cnt_clear),
    .i_limit   (s_ff.st == HS_RSTHI ? 32'(RST_HIGH_CYC - 1) : 32'(INIT_CYCLES - 1)),
    .o_done    (cnt_done)
  );
  // A registered restart flag clears the count, so no loop runs from the count back through the next state.
  assign cnt_clear = i_rst || s_ff.restart || (s_ff.st != HS_RSTHI && s_ff.st != HS_INIT);

  always_comb begin
    nxt_s      = s_ff;
    nxt_s.done = 1'b0;
    nxt_s.restart = 1'b0;
    unique case (s_ff.st)
      HS_IDLE: begin
        if (i_dev_reset_req) begin
          nxt_s.st    = HS_RSTHI;
          nxt_s.rst_o = 1'b1;
        end else if (i_req) begin
          nxt_s.st    = HS_STROBE;
          nxt_s.write = i_req_write;
          nxt_s.addr  = i_req_addr;
          nxt_s.wdata = i_req_wdata;
        end
      end
      HS_STROBE: begin
        if (bus.host_wait_n) begin
          nxt_s.st = HS_END;
        end
      end
      HS_END: begin
        if (bus.host_wait_n) begin
          nxt_s.st    = HS_IDLE;
          nxt_s.done  = 1'b1;
          nxt_s.rdata = s_ff.write ? s_ff.rdata : bus.host_reg_data;
        end
      end
      HS_RSTHI: begin
        if (cnt_done) begin
          nxt_s.st      = HS_INIT;
          nxt_s.rst_o   = 1'b0;
          nxt_s.restart = 1'b1;
        end
      end
      HS_INIT: begin
        if (cnt_done) begin
          nxt_s.st = HS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s_ff <= '{st: HS_IDLE, write: 1'b0, addr: ZERO_BYTE, wdata: ZERO_BYTE,
                rdata: ZERO_BYTE, done: 1'b0, rst_o: 1'b0, restart: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  logic strobe;
  assign strobe             = s_ff.st == HS_STROBE || s_ff.st == HS_END;
  assign bus.host_reg_addr  = s_ff.addr;
  assign bus.host_select_n  = !strobe;
  assign bus.host_read_n    = !(strobe && !s_ff.write);
  assign bus.host_write_n   = !(strobe && s_ff.write);
  assign bus.host_data_h    = s_ff.wdata;
  assign bus.host_data_h_oe = strobe && s_ff.write;
  assign bus.dev_reset      = s_ff.rst_o;
  assign bus.dev_stop       = i_stop;
  assign o_busy             = s_ff.st != HS_IDLE;
  assign o_done             = s_ff.done;
  assign o_rdata            = s_ff.rdata;
  assign o_irq              = bus.host_irq;
endmodule
`default_nettype wire

// >>> dspcp_monitor.sv
// Assertion checker watching the host port bus.
`timescale 1ns/1ps
`default_nettype none
module dspcp_monitor
  import dspcp_pkg::*;
(
  input wire logic              i_sys_clk,
  input wire logic              i_rst,
  input wire logic [ADDR_W-1:0] host_reg_addr,
  input wire logic              host_data_h_oe,
  input wire logic              host_data_d_oe,
  input wire logic              host_select_n,
  input wire logic              host_read_n,
  input wire logic              host_write_n,
  input wire logic              host_wait_n,
  input wire logic              host_irq,
  input wire logic              dev_reset,
  input wire logic              dev_stop
);
  // ----------------------------------------
  // Pulse width counter
  // ----------------------------------------
  // The width is judged at the falling edge, so the count must survive until then.
  logic [15:0] rst_hi_ff;
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rst_hi_ff <= 16'h0000;
    end else begin
      rst_hi_ff <= dev_reset ? rst_hi_ff + 16'h0001 : 16'h0000;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  bus_no_clash_a: assert property (!(host_data_d_oe && host_data_h_oe))
    else $error("both ends drive data");
  read_drive_a: assert property ($rose(host_data_d_oe) |-> !host_select_n && !host_read_n)
    else $error("read data without read");
  wait_cause_a: assert property ($fell(host_wait_n) |-> $past(!host_select_n && !(host_read_n && host_write_n)))
    else $error("wait without access");
  wait_len_a: assert property ($fell(host_wait_n) |=> !host_wait_n ##1 host_wait_n)
    else $error("wait length wrong");
  strobe_hold_a: assert property (!host_wait_n |-> !host_select_n && $stable(host_reg_addr))
    else $error("access dropped during wait");
  strobe_excl_a: assert property (host_read_n || host_write_n)
    else $error("read and write together");
  irq_clear_a: assert property ($fell(host_irq) |-> $past(!host_select_n && !host_read_n && host_reg_addr == IRQ_REG_ADDR))
    else $error("irq dropped without service");
  stop_refuse_a: assert property (dev_stop && host_wait_n |=> host_wait_n)
    else $error("access taken in stop");
  init_refuse_a: assert property (dev_reset |=> host_wait_n)
    else $error("access taken in reset");
  reset_width_a: assert property ($fell(dev_reset) |-> 32'(rst_hi_ff) >= RST_HIGH_CYC)
    else $error("reset pulse too short");
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking bench joining the host end and the device end.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dspcp_pkg::*;
  localparam int unsigned INIT_SIM = 50;
  logic sys_clk, rst, req, req_write, core_we, irq_en, dev_rst_req, stop;
  logic [7:0] req_addr, req_wdata, core_addr, core_wdata, rdata, wr_addr, wr_data;
  logic busy, done, irq, host_wr, ready, stopped;
  logic [15:0] wr_seen, hi_cnt, init_cnt;
  int err_total, tests_run;
  dspcp_if bus_if();
  dspcp_device #(.INIT_CYCLES(INIT_SIM)) dspcp_device_inst (.i_sys_clk(sys_clk), .i_rst(rst), .bus(bus_if.device),
    .i_core_we(core_we), .i_core_addr(core_addr), .i_core_wdata(core_wdata), .i_irq_enable(irq_en),
    .o_host_wr(host_wr), .o_host_wr_addr(wr_addr), .o_host_wr_data(wr_data), .o_ready(ready), .o_stopped(stopped));
  dspcp_host #(.INIT_CYCLES(INIT_SIM)) dspcp_host_inst (.i_sys_clk(sys_clk), .i_rst(rst), .bus(bus_if.host),
    .i_req(req), .i_req_write(req_write), .i_req_addr(req_addr), .i_req_wdata(req_wdata),
    .i_dev_reset_req(dev_rst_req), .i_stop(stop), .o_busy(busy), .o_done(done), .o_rdata(rdata), .o_irq(irq));
  dspcp_monitor dspcp_monitor_inst (.i_sys_clk(sys_clk), .i_rst(rst), .host_reg_addr(bus_if.host_reg_addr),
    .host_data_h_oe(bus_if.host_data_h_oe), .host_data_d_oe(bus_if.host_data_d_oe),
    .host_select_n(bus_if.host_select_n), .host_read_n(bus_if.host_read_n), .host_write_n(bus_if.host_write_n),
    .host_wait_n(bus_if.host_wait_n), .host_irq(bus_if.host_irq), .dev_reset(bus_if.dev_reset),
    .dev_stop(bus_if.dev_stop));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (host_wr === 1'b1) wr_seen <= {wr_addr, wr_data};
    if (bus_if.dev_reset === 1'b1) begin
      hi_cnt <= hi_cnt + 16'h0001;
      init_cnt <= 16'h0000;
    end else if (ready === 1'b0) init_cnt <= init_cnt + 16'h0001;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Bounded so that a stuck handshake ends the run instead of hanging it.
  task automatic wait_lvl(input int sel, input logic lvl);
    int n;
    for (n = 0; n < 2000 && (sel == 0 ? done : sel == 1 ? ready : busy) !== lvl; n++) tick(1);
    if (n == 2000) begin
      err_total++;
      $display("[FAIL] %0t ns: wait timed out", $time);
      close_out();
    end
  endtask
  task automatic host_op(input logic wr, input logic [7:0] a, input logic [7:0] d);
    req = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    tick(1);
    req = 1'b0;
    wait_lvl(0, 1'b1);
  endtask
  task automatic core_irq(input logic en);
    irq_en = en;
    core_we = 1'b1;
    tick(1);
    core_we = 1'b0;
    tick(3);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_access();
    host_op(1'b1, 8'h12, 8'h5A);
    check(wr_seen, 16'h125A);
    host_op(1'b1, 8'h34, 8'hA5);
    check(wr_seen, 16'h34A5);
    host_op(1'b0, 8'h12, 8'h00);
    check({8'h00, rdata}, 16'h005A);
    host_op(1'b0, 8'h34, 8'h00);
    check({8'h00, rdata}, 16'h00A5);
  endtask
  task automatic t_irq();
    core_addr = IRQ_REG_ADDR;
    core_wdata = 8'h01;
    core_irq(1'b0);
    check({15'h0000, irq}, 16'h0000);
    core_irq(1'b1);
    check({15'h0000, irq}, 16'h0001);
    host_op(1'b0, 8'h12, 8'h00);
    check({15'h0000, irq}, 16'h0001);
    host_op(1'b0, IRQ_REG_ADDR, 8'h00);
    check({8'h00, rdata}, 16'h0001);
    tick(2);
    check({15'h0000, irq}, 16'h0000);
  endtask
  task automatic t_stop();
    stop = 1'b1;
    tick(2);
    check({14'h0000, stopped, bus_if.dev_stop}, 16'h0003);
    host_op(1'b1, 8'h12, 8'hEE);
    check(wr_seen, 16'h34A5);
    stop = 1'b0;
    tick(2);
    check({14'h0000, stopped, bus_if.dev_stop}, 16'h0000);
    host_op(1'b0, 8'h12, 8'h00);
    check({8'h00, rdata}, 16'h005A);
  endtask
  task automatic t_reset();
    logic [15:0] base;
    base = hi_cnt;
    dev_rst_req = 1'b1;
    tick(1);
    dev_rst_req = 1'b0;
    wait_lvl(1, 1'b0);
    wait_lvl(1, 1'b1);
    check({15'h0000, hi_cnt - base >= RST_HIGH_CYC}, 16'h0001);
    check({15'h0000, init_cnt >= INIT_SIM}, 16'h0001);
    wait_lvl(2, 1'b0);
    host_op(1'b1, 8'h56, 8'hC3);
    host_op(1'b0, 8'h56, 8'h00);
    check({8'h00, rdata}, 16'h00C3);
  endtask
  initial begin
    {rst, req, req_write, core_we, irq_en, dev_rst_req, stop} = 7'h40;
    {req_addr, req_wdata, core_addr, core_wdata} = 32'h0000_0000;
    {err_total, tests_run, hi_cnt, init_cnt, wr_seen} = 0;
    tick(20);
    rst = 1'b0;
    wait_lvl(1, 1'b1);
    wait_lvl(2, 1'b0);
    t_access();
    t_irq();
    t_stop();
    t_reset();
    close_out();
  end
endmodule
`default_nettype wire
